// ==== logic/dma_ctrl_pkg.sv ====
// shared constants and types for the descriptor dma control block
package dma_ctrl_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [1:0] REG_TX_REQUEST = 2'h0;
  localparam logic [1:0] REG_RX_REQUEST = 2'h1;
  localparam logic [1:0] REG_TX_BASE = 2'h2;
  localparam logic [1:0] REG_RX_BASE = 2'h3;
  localparam int REQUEST_BIT = 0;
  localparam logic [31:0] REQUEST_RESET = 32'h0;
  localparam logic [31:0] BASE_RESET = 32'h0;
  localparam logic [1:0] DL_16 = 2'h0;
  localparam logic [1:0] DL_32 = 2'h1;
  localparam logic [1:0] DL_64 = 2'h2;
  localparam logic [1:0] DL_RESET = 2'h0;
  localparam int SOFT_RESET_CYCLES = 64;
  typedef enum logic [1:0] {DIR_TX, DIR_RX} dir_t;
endpackage

// ==== logic/dma_ctrl_if.sv ====
// link between the dma engine and the software side that drives its registers
interface dma_ctrl_if;
  logic regWrite;
  logic [1:0] regIndex;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic [1:0] descLength;
  logic softReset;
  logic softResetBusy;
  modport engine (input regWrite, regIndex, regWdata, descLength, softReset,
    output regRdata, softResetBusy);
  modport software (output regWrite, regIndex, regWdata, descLength, softReset,
    input regRdata, softResetBusy);
endinterface

// ==== logic/dma_engine.sv ====
// descriptor dma engine: request bits, list bases, descriptor walking
// Function
// [R1] tx request one fetches descriptor at tx base
// [R2] tx transfer starts only on valid descriptor
// [R3] after transfer fetch next, continue while valid
// [R4] invalid tx descriptor clears request, halts
// [R5] writing zero to tx request does nothing
// [R6] tx request reads one while active, resets zero
// [R7] rx request one fetches descriptor at rx base
// [R8] rx starts on valid descriptor and frame present
// [R9] rx continues while valid, standby when empty
// [R10] invalid rx descriptor clears request, halts
// [R11] clearing rx request mid-frame corrupts pointer
// [R12] software stops mac receiver before clearing rx
// [R13] tx base aligned to descriptor length
// [R14] rx base aligned to descriptor length
// [R15] tx base changed only while tx halted; the engine takes tx base writes in any tx state
// [R16] rx base changed only while rx halted; the engine takes rx base writes in any rx state
// [R17] unused request bits read zero, written zero
// [R18] length code selects 16, 32, 64 bytes
// [R19] soft reset spans 64 cycles, bases kept
// [R20] next address is current plus descriptor length
module dma_engine
  import dma_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  dma_ctrl_if.engine bus,
  output logic txFetchReq,
  output logic rxFetchReq,
  output logic [31:0] txFetchAddr,
  output logic [31:0] rxFetchAddr,
  input wire logic txDescDone,
  input wire logic txDescriptorValid,
  input wire logic rxDescDone,
  input wire logic rxDescriptorValid,
  input wire logic rxFrameReady,
  output logic txTransferGo,
  output logic rxTransferGo,
  input wire logic txTransferDone,
  input wire logic rxTransferDone
);
  import dma_ctrl_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_WAIT, S_STANDBY, S_XFER} chan_t;
  chan_t txState_reg, rxState_reg;
  logic txRequest_reg, rxRequest_reg;
  logic [31:0] txBase_reg, rxBase_reg, txAddr_reg, rxAddr_reg;
  logic [6:0] srCount_reg;
  logic srActive;
  logic txWrite, rxWrite;

  function automatic logic [31:0] descBytes(input logic [1:0] code);
    if (code == DL_16) begin
      descBytes = 32'h10;
    end else if (code == DL_32) begin
      descBytes = 32'h20;
    end else begin
      descBytes = 32'h40; // reserved code treated as 64 bytes [R18]
    end
  endfunction

  // next descriptor sits one descriptor length further on
  function automatic logic [31:0] nextDescAddr(input logic [31:0] addr, input logic [1:0] code);
    nextDescAddr = addr + descBytes(code);
  endfunction

  // only the request flag is live; the upper bits always read zero
  function automatic logic [31:0] requestWord(input logic active);
    requestWord = {31'h0, active};
  endfunction

  assign srActive = (srCount_reg != 7'h0);
  assign bus.softResetBusy = srActive;
  assign txWrite = bus.regWrite && !srActive && bus.regIndex == REG_TX_REQUEST;
  assign rxWrite = bus.regWrite && !srActive && bus.regIndex == REG_RX_REQUEST;

  // soft reset window; registers must not be touched while it runs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      srCount_reg <= 7'h0;
    end else if (clkEn) begin
      if (bus.softReset) begin
        srCount_reg <= 7'(SOFT_RESET_CYCLES); // [R19]
      end else if (srActive) begin
        srCount_reg <= srCount_reg - 7'h1;
      end
    end
  end

  // list bases survive the soft reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txBase_reg <= BASE_RESET;
      rxBase_reg <= BASE_RESET;
    end else if (clkEn && bus.regWrite && !srActive) begin
      if (bus.regIndex == REG_TX_BASE) begin
        txBase_reg <= bus.regWdata; // alignment is software's duty [R13] [R15]
      end else if (bus.regIndex == REG_RX_BASE) begin
        rxBase_reg <= bus.regWdata; // [R14] [R16]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || bus.softReset) begin
      txRequest_reg <= 1'b0;
      txState_reg <= S_IDLE;
      txAddr_reg <= BASE_RESET;
    end else if (clkEn) begin
      case (txState_reg)
        S_IDLE: begin
          if (txWrite && bus.regWdata[REQUEST_BIT]) begin // zero write ignored [R5]
            txRequest_reg <= 1'b1; // [R6]
            txAddr_reg <= txBase_reg; // [R1]
            txState_reg <= S_FETCH;
          end
        end
        S_FETCH: txState_reg <= S_WAIT;
        S_WAIT: begin
          if (txDescDone) begin
            if (txDescriptorValid) begin
              txState_reg <= S_XFER; // [R2]
            end else begin
              txRequest_reg <= 1'b0; // [R4]
              txState_reg <= S_IDLE;
            end
          end
        end
        S_XFER: begin
          if (txTransferDone) begin
            txAddr_reg <= nextDescAddr(txAddr_reg, bus.descLength); // [R20]
            txState_reg <= S_FETCH; // [R3]
          end
        end
        default: txState_reg <= S_IDLE;
      endcase
    end
  end

  // no frame guard on a zero write: mid-frame clears lose write-back
  always_ff @(posedge clk_sys) begin
    if (!reset_n || bus.softReset) begin
      rxRequest_reg <= 1'b0;
      rxState_reg <= S_IDLE;
      rxAddr_reg <= BASE_RESET;
    end else if (clkEn) begin
      if (rxWrite && !bus.regWdata[REQUEST_BIT]) begin
        rxRequest_reg <= 1'b0; // abrupt stop, pointer left as is [R11] [R12]
        rxState_reg <= S_IDLE;
      end else begin
        case (rxState_reg)
          S_IDLE: begin
            if (rxWrite && bus.regWdata[REQUEST_BIT]) begin
              rxRequest_reg <= 1'b1;
              rxAddr_reg <= rxBase_reg; // [R7]
              rxState_reg <= S_FETCH;
            end
          end
          S_FETCH: rxState_reg <= S_WAIT;
          S_WAIT: begin
            if (rxDescDone) begin
              if (rxDescriptorValid) begin
                rxState_reg <= S_STANDBY;
              end else begin
                rxRequest_reg <= 1'b0; // [R10]
                rxState_reg <= S_IDLE;
              end
            end
          end
          // a valid descriptor waits here until the fifo holds a frame
          S_STANDBY: begin
            if (rxFrameReady) begin
              rxState_reg <= S_XFER; // [R8] [R9]
            end
          end
          S_XFER: begin
            if (rxTransferDone) begin
              rxAddr_reg <= nextDescAddr(rxAddr_reg, bus.descLength); // [R20]
              rxState_reg <= S_FETCH; // [R9]
            end
          end
          default: rxState_reg <= S_IDLE;
        endcase
      end
    end
  end

  // fetch address stands until the transfer on it has ended
  assign txFetchReq = (txState_reg == S_FETCH);
  assign rxFetchReq = (rxState_reg == S_FETCH);
  assign txFetchAddr = txAddr_reg;
  assign rxFetchAddr = rxAddr_reg;
  assign txTransferGo = (txState_reg == S_XFER);
  assign rxTransferGo = (rxState_reg == S_XFER);

  // readback is combinational; the software end registers it
  always_comb begin
    if (bus.regIndex == REG_TX_REQUEST) begin
      bus.regRdata = requestWord(txRequest_reg); // [R17] [R6]
    end else if (bus.regIndex == REG_RX_REQUEST) begin
      bus.regRdata = requestWord(rxRequest_reg); // [R17]
    end else if (bus.regIndex == REG_TX_BASE) begin
      bus.regRdata = txBase_reg;
    end else begin
      bus.regRdata = rxBase_reg;
    end
  end
endmodule // dma_engine

// ==== logic/dma_software.sv ====
// software-side end: turns simple user commands into register accesses
module dma_software
  import dma_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  dma_ctrl_if.software bus,
  input wire logic cmdWrite,
  input wire logic [1:0] cmdIndex,
  input wire logic [31:0] cmdData,
  input wire logic [1:0] cmdLength,
  input wire logic cmdSoftReset,
  output logic cmdAccepted,
  output logic [31:0] readData
);
  import dma_ctrl_pkg::*;

  logic [1:0] length_reg;
  logic pending;
  logic [31:0] lowMask;

  assign lowMask = (length_reg == DL_16) ? 32'hF : (length_reg == DL_32) ? 32'h1F : 32'h3F;
  // request writes carry zeros in unused bits; base writes are forced aligned
  assign pending = cmdWrite && clkEn && !bus.softResetBusy && !cmdSoftReset;
  assign cmdAccepted = pending;
  assign bus.regWrite = pending;
  assign bus.regIndex = cmdIndex;
  assign bus.regWdata = (cmdIndex == REG_TX_REQUEST || cmdIndex == REG_RX_REQUEST) ?
    {31'h0, cmdData[REQUEST_BIT]} : (cmdData & ~lowMask); // [R17] [R13] [R14]
  assign bus.descLength = length_reg;
  assign bus.softReset = cmdSoftReset && clkEn;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      length_reg <= DL_RESET;
    end else if (clkEn && cmdLength != 2'h3) begin
      length_reg <= cmdLength; // reserved code refused [R18]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      readData <= 32'h0;
    end else if (clkEn) begin
      readData <= bus.regRdata;
    end
  end
endmodule // dma_software

// ==== sim/dma_ctrl_asserts.sv ====
// concurrent checks on the register link between the software end and the engine
module dma_ctrl_asserts
  import dma_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic [1:0] regIndex,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic [1:0] descLength,
  input wire logic softReset,
  input wire logic softResetBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] busyCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !softResetBusy) busyCnt <= 8'h0;
    else busyCnt <= busyCnt + 8'h1;
  end
  AST_TX_SET: assert property (
    regWrite && regIndex == REG_TX_REQUEST && regWdata[0] && !softResetBusy
    |=> regIndex != REG_TX_REQUEST || regRdata == 32'h1) else $error("tx request not set");
  AST_RX_SET: assert property (
    regWrite && regIndex == REG_RX_REQUEST && regWdata[0] && !softResetBusy
    |=> regIndex != REG_RX_REQUEST || regRdata == 32'h1) else $error("rx request not set");
  AST_UNUSED_ZERO: assert property (!regIndex[1] |-> regRdata[31:1] == 31'h0)
    else $error("unused request bits not zero");
  AST_BASE_KEPT: assert property (
    regWrite && regIndex[1] && !softResetBusy ##1 regIndex == $past(regIndex)
    |-> regRdata == $past(regWdata)) else $error("base readback wrong");
  AST_LEN_LEGAL: assert property (descLength != 2'h3)
    else $error("reserved length reached engine");
  AST_SR_SPAN: assert property (
    $fell(softResetBusy) && $past(reset_n) |-> busyCnt == 8'(SOFT_RESET_CYCLES))
    else $error("soft reset span wrong");
  AST_SR_BOUND: assert property (busyCnt <= 8'(SOFT_RESET_CYCLES))
    else $error("soft reset overran");
  AST_SR_CLEARS: assert property (
    $fell(softResetBusy) && $past(reset_n) && !regIndex[1] |-> regRdata == 32'h0)
    else $error("request survived soft reset");
  AST_NO_WR_BUSY: assert property (softResetBusy |-> !regWrite)
    else $error("write during soft reset");
  COV_SR: cover property (softReset ##[1:3] softResetBusy);
  COV_TX: cover property (regWrite && regIndex == REG_TX_REQUEST && regWdata[0]);
  COV_BASE: cover property (regWrite && regIndex[1]);
  COV_RX: cover property (regWrite && regIndex == REG_RX_REQUEST && regWdata[0]);
endmodule // dma_ctrl_asserts

// ==== sim/ethernet_descriptor_dma_control_tb.sv ====
// self-checking bench: software end and engine joined by the register link
module ethernet_descriptor_dma_control_tb
  import dma_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, en = 1'b1, cmdWrite = 1'b0, cmdSoftReset = 1'b0;
  logic txValid = 1'b0, rxValid = 1'b0, frameReady = 1'b0;
  logic [1:0] cmdIndex = 2'h0, cmdLength = 2'h0;
  logic [3:0] pul = 4'h0;
  logic [31:0] cmdData = 32'h0, txAddr, rxAddr, readData;
  logic txFetchReq, rxFetchReq, txGo, rxGo, cmdAccepted;
  int n_errors = 0, compares = 0;
  dma_ctrl_if link();
  wire logic [5:0] ev = {~link.softResetBusy, cmdAccepted, rxGo, txGo, rxFetchReq, txFetchReq};
  dma_software dma_software_i (.clk_sys, .reset_n, .clkEn(en), .bus(link.software), .cmdWrite,
    .cmdIndex, .cmdData, .cmdLength, .cmdSoftReset, .cmdAccepted, .readData);
  dma_engine dma_engine_i (.clk_sys, .reset_n, .clkEn(en), .bus(link.engine), .txFetchReq,
    .rxFetchReq, .txFetchAddr(txAddr), .rxFetchAddr(rxAddr), .txDescDone(pul[0]),
    .txDescriptorValid(txValid), .rxDescDone(pul[1]), .rxDescriptorValid(rxValid),
    .rxFrameReady(frameReady), .txTransferGo(txGo), .rxTransferGo(rxGo),
    .txTransferDone(pul[2]), .rxTransferDone(pul[3]));
  dma_ctrl_asserts dma_ctrl_asserts_i (.clk_sys, .reset_n, .regWrite(link.regWrite),
    .regIndex(link.regIndex), .regWdata(link.regWdata), .regRdata(link.regRdata),
    .descLength(link.descLength), .softReset(link.softReset),
    .softResetBusy(link.softResetBusy));
  always #2.5 clk_sys = ~clk_sys;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait; a hang is a mismatch and ends the run
  task automatic waitFor(int b);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ev[b] !== 1'b1 && i < 100);
    if (ev[b] !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: wait on event %0d timed out", $time, b);
      print_verdict();
    end
  endtask
  // request held until the edge that samples the accept
  task automatic wr(logic [1:0] idx, logic [31:0] data);
    @(posedge clk_sys);
    cmdWrite <= 1'b1;
    cmdIndex <= idx;
    cmdData <= data;
    waitFor(4);
    cmdWrite <= 1'b0;
  endtask
  task automatic rd(logic [1:0] idx, logic [31:0] exp);
    @(posedge clk_sys);
    cmdIndex <= idx;
    repeat (3) @(posedge clk_sys);
    chk(readData, exp);
  endtask
  task automatic give(int k, logic v);
    txValid <= v;
    rxValid <= v;
    pul[k] <= 1'b1;
    @(posedge clk_sys);
    pul[k] <= 1'b0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rd(2'(i), 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_tx;
    cmdLength <= DL_32;
    wr(REG_TX_BASE, 32'h100);
    wr(REG_TX_REQUEST, 32'h1);
    waitFor(0);
    chk(txAddr, 32'h100);
    chk({31'h0, txGo}, 32'h0);
    give(0, 1'b1);
    waitFor(2);
    wr(REG_TX_REQUEST, 32'h0);
    rd(REG_TX_REQUEST, 32'h1);
    give(2, 1'b0);
    waitFor(0);
    chk(txAddr, 32'h120);
    give(0, 1'b0);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, txGo}, 32'h0);
    rd(REG_TX_REQUEST, 32'h0);
    $display("test tx walk done");
  endtask
  task automatic t_rx;
    cmdLength <= DL_64;
    wr(REG_RX_BASE, 32'h200);
    wr(REG_RX_REQUEST, 32'h1);
    waitFor(1);
    chk(rxAddr, 32'h200);
    give(1, 1'b1);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, rxGo}, 32'h0);
    cmdLength <= 2'h3;
    frameReady <= 1'b1;
    waitFor(3);
    give(3, 1'b0);
    waitFor(1);
    chk(rxAddr, 32'h240);
    give(1, 1'b0);
    frameReady <= 1'b0;
    rd(REG_RX_REQUEST, 32'h0);
    chk({31'h0, rxGo}, 32'h0);
    // restart, then stop from standby while no frame is in flight
    wr(REG_RX_REQUEST, 32'h1);
    waitFor(1);
    chk(rxAddr, 32'h200);
    give(1, 1'b1);
    rd(REG_RX_REQUEST, 32'h1);
    wr(REG_RX_REQUEST, 32'h0);
    rd(REG_RX_REQUEST, 32'h0);
    chk({31'h0, rxGo}, 32'h0);
    $display("test rx walk done");
  endtask
  // soft reset lands while a fetch is outstanding
  task automatic t_soft;
    wr(REG_TX_REQUEST, 32'h1);
    waitFor(0);
    cmdSoftReset <= 1'b1;
    @(posedge clk_sys);
    cmdSoftReset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    waitFor(5);
    rd(REG_TX_REQUEST, 32'h0);
    rd(REG_TX_BASE, 32'h100);
    $display("test soft reset done");
  endtask
  // shortest descriptors, walked from the base that the soft reset kept
  task automatic t_len16;
    cmdLength <= DL_16;
    wr(REG_TX_REQUEST, 32'h1);
    waitFor(0);
    chk(txAddr, 32'h100);
    give(0, 1'b1);
    waitFor(2);
    give(2, 1'b0);
    waitFor(0);
    chk(txAddr, 32'h110);
    give(0, 1'b0);
    rd(REG_TX_REQUEST, 32'h0);
    $display("test short descriptors done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_soft();
    t_len16();
    print_verdict();
  end
endmodule // ethernet_descriptor_dma_control_tb
